/* logic/txm_pkg.sv */
// constants for the transmit multiplier configuration register bank
package txm_pkg;

  // serial frame shape
  localparam int          ADDR_W      = 15;
  localparam int          INSTR_BITS  = 16;
  localparam int          DATA_BITS   = 8;
  localparam logic [4:0]  INSTR_LAST  = 5'h0F;
  localparam logic [2:0]  DATA_LAST   = 3'h7;

  // register offsets
  localparam logic [14:0] ADDR_CFG_A      = 15'h0000;
  localparam logic [14:0] ADDR_CFG_B      = 15'h0001;
  localparam logic [14:0] ADDR_DEV_CFG    = 15'h0002;
  localparam logic [14:0] ADDR_PART_KIND  = 15'h0003;
  localparam logic [14:0] ADDR_PART_HI    = 15'h0004;
  localparam logic [14:0] ADDR_PART_LO    = 15'h0005;
  localparam logic [14:0] ADDR_SCRATCH    = 15'h000A;
  localparam logic [14:0] ADDR_PORT_REV   = 15'h000B;
  localparam logic [14:0] ADDR_MAKER_HI   = 15'h000C;
  localparam logic [14:0] ADDR_MAKER_LO   = 15'h000D;
  localparam logic [14:0] ADDR_XFER       = 15'h000F;
  localparam logic [14:0] ADDR_PWR        = 15'h0010;
  localparam logic [14:0] ADDR_MULT_LM    = 15'h0011;
  localparam logic [14:0] ADDR_MULT_HI    = 15'h0012;
  localparam logic [14:0] ADDR_RF_BUF     = 15'h0013;
  localparam logic [14:0] ADDR_SPLIT      = 15'h0014;
  localparam logic [14:0] ADDR_AMP        = 15'h0015;
  localparam logic [14:0] ADDR_TX_SETUP   = 15'h0016;
  localparam logic [14:0] ADDR_TX_SETUP2  = 15'h0017;
  localparam logic [14:0] ADDR_MULT_SETUP = 15'h0018;
  localparam logic [14:0] ADDR_TX_STATE0  = 15'h0019;
  localparam logic [14:0] ADDR_TX_STATEN  = 15'h0038;
  localparam int          TX_STATE_BYTES  = 32;

  // values after reset, and the config B writable-bit mask
  localparam logic [3:0]  RST_CFG_A_HI   = 4'h1;
  localparam logic [7:0]  RST_CFG_B      = 8'h00;
  localparam logic [7:0]  CFG_B_RW_MASK  = 8'hF6;
  localparam logic [7:0]  RST_DEV_CFG    = 8'h10;
  localparam logic [7:0]  RST_SCRATCH    = 8'h00;
  localparam logic        RST_PWR        = 1'b1;
  localparam logic [7:0]  RST_MULT_LM    = 8'hBB;
  localparam logic [3:0]  RST_MULT_HI    = 4'hB;
  localparam logic [7:0]  RST_RF_BUF     = 8'h75;
  localparam logic [7:0]  RST_SPLIT      = 8'hB5;
  localparam logic [3:0]  RST_AMP        = 4'hC;
  localparam logic [7:0]  RST_TX_SETUP   = 8'h10;
  localparam logic [6:0]  RST_TX_DEPTH   = 7'h00;
  localparam logic [7:0]  RST_MULT_SETUP = 8'h10;
  localparam logic [7:0]  RST_TX_STATE   = 8'h00;

  // field positions: interface config A upper nibble, sequencer setup byte
  localparam int CFGA_SDO_ACTIVE = 0;
  localparam int CFGA_ADDR_ASC   = 1;
  localparam int CFGA_LSB_FIRST  = 2;
  localparam int CFGA_SOFT_RST   = 3;
  localparam int BIT_SEQ_EN      = 7;
  localparam int BIT_SLP_CTRL    = 6;
  localparam int BIT_SLP_HOLD    = 5;
  localparam int BIT_LATCH_BYP   = 4;

  // pin synchroniser: csb idles high
  localparam int         SYNC_W   = 7;
  localparam logic [6:0] SYNC_RST = 7'h01;

endpackage

/* logic/txm_regs.sv */
// register bank and transmit sequencer control for the multiplier transmitter
`timescale 1ns/1ps
// Function
// - setup bit 7 enables transmit sequencer, bit 6 sleep control; both reset zero.
// - setup bit 5 freezes sequencer state while multiplier sleeps; resets zero.
// - setup bit 4 bypasses control latch, resets one; bits 3..0 read zero.
// - 0x011 holds low-band bias [3:0], mid-band [7:4]; resets 0xBB.
// - 0x012 holds high-band bias [3:0], upper nibble reserved; resets 0x0B.
// - 0x013 holds buffer input bias [3:0], output bias [7:4]; resets 0x75.
// - 0x014 holds splitter first stage [3:0], second [7:4]; resets 0xB5.
// - 0x015 holds amplifier bias [3:0], upper nibble read-only; resets 0x0C.
// - next setup register holds 7-bit sequencer depth, reset zero, bit 7 reserved.
// - per-state 4-bit modes, two per byte after multiplier setup, reset zero.
module txm_regs #(
  parameter logic [7:0] PART_KIND  = 8'h5A,
  parameter logic [7:0] PART_HI    = 8'h12,
  parameter logic [7:0] PART_LO    = 8'h34,
  parameter logic [7:0] PORT_REV   = 8'h01,
  parameter logic [7:0] MAKER_HI   = 8'h00,
  parameter logic [7:0] MAKER_LO   = 8'h42
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       srst,
  // serial control port pins
  input  wire logic       spi_csb_n,
  input  wire logic       spi_sclk,
  input  wire logic       spi_sdio_in,
  output logic            spi_sdio_out,
  output logic            spi_sdio_oe,
  output logic            spi_sdo_out,
  output logic            spi_sdo_oe,
  // sequencer control pins
  input  wire logic       tx_seq_reset,
  input  wire logic       tx_seq_advance,
  input  wire logic       tx_latch_load,
  input  wire logic       mult_sleep,
  // analog settings
  output logic            chip_power_up,
  output logic      [3:0] multiplier_low_band_bias,
  output logic      [3:0] multiplier_mid_band_bias,
  output logic      [3:0] multiplier_high_band_bias,
  output logic      [3:0] buffer_input_stage_bias,
  output logic      [3:0] buffer_output_stage_bias,
  output logic      [3:0] splitter_first_stage_bias,
  output logic      [3:0] splitter_second_stage_bias,
  output logic      [3:0] amplifier_bias_setting,
  // transmit sequencer
  output logic            transmit_seq_enable,
  output logic            transmit_sleep_control,
  output logic      [6:0] tx_seq_index,
  output logic      [3:0] tx_mode_ctrl,
  output logic            shadow_xfer_pulse
);
  logic [6:0]  pins_s;
  logic        csb_n_s;
  logic        sclk_s;
  logic        sdi_s;
  logic        seq_rst_s;
  logic        adv_s;
  logic        ld_s;
  logic        sleep_s;
  logic        adv_q;
  logic        ld_q;
  logic        adv_rise;
  logic        ld_rise;
  logic [14:0] reg_addr;
  logic        wr_stb;
  logic [7:0]  wr_data;
  logic [7:0]  rd_data;
  logic        sdo_bit;
  logic        sdo_drive;
  logic        soft_req;
  logic        reg_rst;
  logic [3:0]  cfg_a_hi;
  logic [7:0]  cfg_b;
  logic [7:0]  dev_cfg;
  logic [7:0]  scratch;
  logic        pwr;
  logic [7:0]  mult_lm;
  logic [3:0]  mult_hi;
  logic [7:0]  rf_buf;
  logic [7:0]  split;
  logic [3:0]  amp;
  logic [7:0]  tx_setup;
  logic [6:0]  tx_depth;
  logic [7:0]  mult_setup;
  logic [7:0]  tx_state [txm_pkg::TX_STATE_BYTES];
  logic [3:0]  tx_latched;
  logic [3:0]  mode_now;
  logic [3:0]  next_mode;
  logic [6:0]  next_index;
  logic        frozen;

  function automatic logic [3:0] rev4(input logic [3:0] v);
    return {v[0], v[1], v[2], v[3]};
  endfunction

  function automatic logic is_state(input logic [14:0] a);
    return (a >= txm_pkg::ADDR_TX_STATE0) && (a <= txm_pkg::ADDR_TX_STATEN);
  endfunction

  function automatic logic [4:0] state_slot(input logic [14:0] a);
    logic [14:0] d;
    d = a - txm_pkg::ADDR_TX_STATE0;
    return d[4:0];
  endfunction

  txm_sync u_sync (
    .mclk     (mclk),
    .srst     (srst),
    .async_in ({mult_sleep, tx_latch_load, tx_seq_advance, tx_seq_reset,
                spi_sdio_in, spi_sclk, spi_csb_n}),
    .sync_out (pins_s)
  );

  assign {sleep_s, ld_s, adv_s, seq_rst_s, sdi_s, sclk_s, csb_n_s} = pins_s;

  txm_spi u_spi (
    .mclk        (mclk),
    .srst        (srst),
    .csb_n_s     (csb_n_s),
    .sclk_s      (sclk_s),
    .sdi_s       (sdi_s),
    .addr_ascend (cfg_a_hi[txm_pkg::CFGA_ADDR_ASC]),
    .rd_data     (rd_data),
    .reg_addr    (reg_addr),
    .wr_stb      (wr_stb),
    .wr_data     (wr_data),
    .sdo_bit     (sdo_bit),
    .sdo_drive   (sdo_drive)
  );

  // three-wire mode turns the data pin round for readback
  assign spi_sdio_out = sdo_bit;
  assign spi_sdo_out  = sdo_bit;
  assign spi_sdio_oe  = sdo_drive & ~cfg_a_hi[txm_pkg::CFGA_SDO_ACTIVE];
  assign spi_sdo_oe   = sdo_drive & cfg_a_hi[txm_pkg::CFGA_SDO_ACTIVE];

  // soft reset takes effect the cycle after the write
  assign reg_rst = srst | soft_req;

  always_ff @(posedge mclk) begin
    if (reg_rst) begin
      soft_req <= 1'b0;
    end else begin
      soft_req <= wr_stb && (reg_addr == txm_pkg::ADDR_CFG_A) &&
                  (wr_data[7] || wr_data[0]);
    end
  end

  // interface and identification group
  always_ff @(posedge mclk) begin
    if (reg_rst) begin
      cfg_a_hi <= txm_pkg::RST_CFG_A_HI;
      cfg_b    <= txm_pkg::RST_CFG_B;
      dev_cfg  <= txm_pkg::RST_DEV_CFG;
      scratch  <= txm_pkg::RST_SCRATCH;
      pwr      <= txm_pkg::RST_PWR;
    end else if (wr_stb) begin
      case (reg_addr)
        txm_pkg::ADDR_CFG_A:   cfg_a_hi <= wr_data[7:4] | rev4(wr_data[3:0]);
        txm_pkg::ADDR_CFG_B:   cfg_b    <= wr_data & txm_pkg::CFG_B_RW_MASK;
        txm_pkg::ADDR_DEV_CFG: dev_cfg  <= wr_data;
        txm_pkg::ADDR_SCRATCH: scratch  <= wr_data;
        txm_pkg::ADDR_PWR:     pwr      <= wr_data[0];
        default: ;
      endcase
    end
  end

  // transfer bit clears itself and leaves a one-cycle strobe
  always_ff @(posedge mclk) begin
    if (reg_rst) begin
      shadow_xfer_pulse <= 1'b0;
    end else begin
      shadow_xfer_pulse <= wr_stb && (reg_addr == txm_pkg::ADDR_XFER) && wr_data[0];
    end
  end

  // bias group
  always_ff @(posedge mclk) begin
    if (reg_rst) begin
      mult_lm <= txm_pkg::RST_MULT_LM;
      mult_hi <= txm_pkg::RST_MULT_HI;
      rf_buf  <= txm_pkg::RST_RF_BUF;
      split   <= txm_pkg::RST_SPLIT;
      amp     <= txm_pkg::RST_AMP;
    end else if (wr_stb) begin
      case (reg_addr)
        txm_pkg::ADDR_MULT_LM: mult_lm <= wr_data;
        txm_pkg::ADDR_MULT_HI: mult_hi <= wr_data[3:0];
        txm_pkg::ADDR_RF_BUF:  rf_buf  <= wr_data;
        txm_pkg::ADDR_SPLIT:   split   <= wr_data;
        txm_pkg::ADDR_AMP:     amp     <= wr_data[3:0];
        default: ;
      endcase
    end
  end

  // sequencer setup group
  always_ff @(posedge mclk) begin
    if (reg_rst) begin
      tx_setup   <= txm_pkg::RST_TX_SETUP;
      tx_depth   <= txm_pkg::RST_TX_DEPTH;
      mult_setup <= txm_pkg::RST_MULT_SETUP;
    end else if (wr_stb) begin
      case (reg_addr)
        txm_pkg::ADDR_TX_SETUP:   tx_setup   <= {wr_data[7:4], 4'h0};
        txm_pkg::ADDR_TX_SETUP2:  tx_depth   <= wr_data[6:0];
        txm_pkg::ADDR_MULT_SETUP: mult_setup <= wr_data;
        default: ;
      endcase
    end
  end

  // per-state mode table
  always_ff @(posedge mclk) begin
    if (reg_rst) begin
      for (int i = 0; i < txm_pkg::TX_STATE_BYTES; i++) begin
        tx_state[i] <= txm_pkg::RST_TX_STATE;
      end
    end else if (wr_stb && is_state(reg_addr)) begin
      tx_state[state_slot(reg_addr)] <= wr_data;
    end
  end

  // readback; identification values are constants, so writes cannot touch them
  always_comb begin
    rd_data = 8'h00;
    if (is_state(reg_addr)) begin
      rd_data = tx_state[state_slot(reg_addr)];
    end else begin
      case (reg_addr)
        txm_pkg::ADDR_CFG_A:      rd_data = {cfg_a_hi, rev4(cfg_a_hi)};
        txm_pkg::ADDR_CFG_B:      rd_data = cfg_b;
        txm_pkg::ADDR_DEV_CFG:    rd_data = dev_cfg;
        txm_pkg::ADDR_PART_KIND:  rd_data = PART_KIND;
        txm_pkg::ADDR_PART_HI:    rd_data = PART_HI;
        txm_pkg::ADDR_PART_LO:    rd_data = PART_LO;
        txm_pkg::ADDR_SCRATCH:    rd_data = scratch;
        txm_pkg::ADDR_PORT_REV:   rd_data = PORT_REV;
        txm_pkg::ADDR_MAKER_HI:   rd_data = MAKER_HI;
        txm_pkg::ADDR_MAKER_LO:   rd_data = MAKER_LO;
        txm_pkg::ADDR_PWR:        rd_data = {7'h00, pwr};
        txm_pkg::ADDR_MULT_LM:    rd_data = mult_lm;
        txm_pkg::ADDR_MULT_HI:    rd_data = {4'h0, mult_hi};
        txm_pkg::ADDR_RF_BUF:     rd_data = rf_buf;
        txm_pkg::ADDR_SPLIT:      rd_data = split;
        txm_pkg::ADDR_AMP:        rd_data = {4'h0, amp};
        txm_pkg::ADDR_TX_SETUP:   rd_data = tx_setup;
        txm_pkg::ADDR_TX_SETUP2:  rd_data = {1'b0, tx_depth};
        txm_pkg::ADDR_MULT_SETUP: rd_data = mult_setup;
        default:                  rd_data = 8'h00;
      endcase
    end
  end

  // analog settings straight from storage
  assign chip_power_up              = pwr;
  assign multiplier_low_band_bias   = mult_lm[3:0];
  assign multiplier_mid_band_bias   = mult_lm[7:4];
  assign multiplier_high_band_bias  = mult_hi;
  assign buffer_input_stage_bias    = rf_buf[3:0];
  assign buffer_output_stage_bias   = rf_buf[7:4];
  assign splitter_first_stage_bias  = split[3:0];
  assign splitter_second_stage_bias = split[7:4];
  assign amplifier_bias_setting     = amp;
  assign transmit_seq_enable        = tx_setup[txm_pkg::BIT_SEQ_EN];
  assign transmit_sleep_control     = tx_setup[txm_pkg::BIT_SLP_CTRL];

  // sequencer stepping
  always_ff @(posedge mclk) begin
    if (srst) begin
      adv_q <= 1'b0;
      ld_q  <= 1'b0;
    end else begin
      adv_q <= adv_s;
      ld_q  <= ld_s;
    end
  end

  assign adv_rise = adv_s & ~adv_q;
  assign ld_rise  = ld_s & ~ld_q;
  assign frozen   = tx_setup[txm_pkg::BIT_SLP_HOLD] & sleep_s;

  always_comb begin
    next_index = tx_seq_index + 7'h01;
    if (next_index >= tx_depth) begin
      next_index = 7'h00;
    end
  end

  always_ff @(posedge mclk) begin
    if (reg_rst || !transmit_seq_enable || seq_rst_s) begin
      tx_seq_index <= 7'h00;
    end else if (adv_rise && !frozen) begin
      tx_seq_index <= next_index;
    end
  end

  // even states sit in the upper nibble
  always_comb begin
    mode_now = 4'h0;
    if (tx_seq_index[6:1] < 6'(txm_pkg::TX_STATE_BYTES)) begin
      mode_now = tx_seq_index[0] ? tx_state[tx_seq_index[5:1]][3:0]
                                 : tx_state[tx_seq_index[5:1]][7:4];
    end
  end

  always_ff @(posedge mclk) begin
    if (reg_rst) begin
      tx_latched <= 4'h0;
    end else if (ld_rise) begin
      tx_latched <= mode_now;
    end
  end

  assign next_mode = tx_setup[txm_pkg::BIT_LATCH_BYP] ? mode_now : tx_latched;

  always_ff @(posedge mclk) begin
    if (reg_rst) begin
      tx_mode_ctrl <= 4'h0;
    end else begin
      tx_mode_ctrl <= next_mode;
    end
  end

  setup_reset_a: assert property (@(posedge mclk) srst |=>
    (!transmit_seq_enable && !transmit_sleep_control && tx_setup == 8'h10))
    else $error("setup register wrong after reset");

  soft_reset_a: assert property (@(posedge mclk) disable iff (srst)
    (wr_stb && reg_addr == 15'h0000 && (wr_data[7] || wr_data[0])) |=> ##1
    (rf_buf == 8'h75 && mult_lm == 8'hBB && split == 8'hB5 && amp == 4'hC))
    else $error("soft reset did not restore bias values");

  mirror_read_a: assert property (@(posedge mclk) disable iff (reg_rst)
    (wr_stb && reg_addr == 15'h0000 && !wr_data[7] && !wr_data[0]) |=>
    (cfg_a_hi[0] == ($past(wr_data[4]) | $past(wr_data[3])) &&
     cfg_a_hi[1] == ($past(wr_data[5]) | $past(wr_data[2]))))
    else $error("config A mirror nibble mismatch");

  bias_write_a: assert property (@(posedge mclk) disable iff (reg_rst)
    (wr_stb && reg_addr == 15'h0013 && !soft_req) |=> (buffer_output_stage_bias ==
    $past(wr_data[7:4]) && buffer_input_stage_bias == $past(wr_data[3:0])))
    else $error("buffer bias write lost");

  reserved_zero_a: assert property (@(posedge mclk) disable iff (srst)
    (reg_addr == 15'h0015 || reg_addr == 15'h0012 || reg_addr == 15'h0016)
    |-> (reg_addr == 15'h0016 ? rd_data[3:0] == 4'h0 : rd_data[7:4] == 4'h0))
    else $error("reserved bits read nonzero");

  hold_freeze_a: assert property (@(posedge mclk) disable iff (reg_rst)
    (frozen && transmit_seq_enable && !seq_rst_s && adv_rise) |=>
    (tx_seq_index == $past(tx_seq_index)))
    else $error("sequencer stepped while held");

  seq_wrap_a: assert property (@(posedge mclk) disable iff (reg_rst)
    (transmit_seq_enable && !seq_rst_s && adv_rise && !frozen &&
     tx_seq_index + 7'h01 >= tx_depth) |=> (tx_seq_index == 7'h00))
    else $error("sequencer did not wrap at depth");

  bypass_pass_a: assert property (@(posedge mclk) disable iff (reg_rst)
    tx_setup[4] |=> (tx_mode_ctrl == $past(mode_now)))
    else $error("bypassed control not passed through");

  latch_hold_a: assert property (@(posedge mclk) disable iff (reg_rst)
    (!tx_setup[4] && !ld_rise) ##1 (!tx_setup[4] && !ld_rise) |=> $stable(tx_mode_ctrl))
    else $error("latched control changed without load");
endmodule

/* logic/txm_spi.sv */
// serial control port: 16-bit instruction, streamed data bytes
`timescale 1ns/1ps
module txm_spi (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // synchronised pins
  input  wire logic        csb_n_s,
  input  wire logic        sclk_s,
  input  wire logic        sdi_s,
  // configuration
  input  wire logic        addr_ascend,
  // register access
  input  wire logic [7:0]  rd_data,
  output logic      [14:0] reg_addr,
  output logic             wr_stb,
  output logic      [7:0]  wr_data,
  // serial readback
  output logic             sdo_bit,
  output logic             sdo_drive
);
  logic        sclk_q;
  logic        in_instr;
  logic        rd_flag;
  logic        load;
  logic        step;
  logic [4:0]  icnt;
  logic [2:0]  dcnt;
  logic [14:0] instr;
  logic [6:0]  rx;
  logic [7:0]  tx_sh;
  logic        rise;
  logic        fall;

  assign rise = sclk_s & ~sclk_q;
  assign fall = ~sclk_s & sclk_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk_s;
    end
  end

  // frame decode, byte assembly and address stepping
  always_ff @(posedge mclk) begin
    if (srst || csb_n_s) begin
      in_instr <= 1'b1;
      rd_flag  <= 1'b0;
      load     <= 1'b0;
      step     <= 1'b0;
      icnt     <= 5'h00;
      dcnt     <= 3'h0;
      instr    <= 15'h0000;
      rx       <= 7'h00;
      wr_stb   <= 1'b0;
      wr_data  <= 8'h00;
      if (srst) begin
        reg_addr <= 15'h0000;
      end
    end else begin
      wr_stb <= 1'b0;
      load   <= step;
      step   <= 1'b0;
      if (step) begin
        reg_addr <= addr_ascend ? reg_addr + 15'h0001 : reg_addr - 15'h0001;
      end
      if (rise && in_instr) begin
        instr <= {instr[13:0], sdi_s};
        icnt  <= icnt + 5'h01;
        if (icnt == txm_pkg::INSTR_LAST) begin
          in_instr <= 1'b0;
          rd_flag  <= instr[14];
          reg_addr <= {instr[13:0], sdi_s};
          load     <= 1'b1;
        end
      end else if (rise) begin
        rx   <= {rx[5:0], sdi_s};
        dcnt <= dcnt + 3'h1;
        if (dcnt == txm_pkg::DATA_LAST) begin
          wr_stb  <= ~rd_flag;
          wr_data <= {rx, sdi_s};
          step    <= 1'b1;
        end
      end
    end
  end

  // readback shifter: bits leave on falling sclk edges, msb first
  always_ff @(posedge mclk) begin
    if (srst || csb_n_s) begin
      tx_sh     <= 8'h00;
      sdo_bit   <= 1'b0;
      sdo_drive <= 1'b0;
    end else begin
      sdo_drive <= ~in_instr & rd_flag;
      if (load) begin
        tx_sh <= rd_data;
      end else if (fall && !in_instr && rd_flag) begin
        sdo_bit <= tx_sh[7];
        tx_sh   <= {tx_sh[6:0], 1'b0};
      end
    end
  end
endmodule

/* logic/txm_sync.sv */
// two-flop synchroniser for pins entering the mclk domain
`timescale 1ns/1ps
module txm_sync (
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      srst,
  // pins and their synchronised copies
  input  wire logic [txm_pkg::SYNC_W-1:0] async_in,
  output logic      [txm_pkg::SYNC_W-1:0] sync_out
);
  logic [txm_pkg::SYNC_W-1:0] stage1;

  always_ff @(posedge mclk) begin
    if (srst) begin
      stage1   <= txm_pkg::SYNC_RST;
      sync_out <= txm_pkg::SYNC_RST;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

/* tb/txm_host.sv */
// serial host model that frames instructions and data on the control port
`timescale 1ns/1ps
module txm_host (
  // clock
  input  wire logic mclk,
  // serial pins
  output logic      csb_n,
  output logic      sclk,
  output logic      sdio,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  initial begin
    csb_n = 1'b1;
    sclk  = 1'b0;
    sdio  = 1'b0;
  end
  // each sclk phase lasts 8 mclk, above the 3 the port needs
  task automatic half();
    repeat (8) @(negedge mclk);
  endtask
  // one frame: instruction word then nb copies of wd, msb first; rd keeps the last byte
  task automatic xfer(input logic [15:0] ins, input logic [7:0] wd, output logic [7:0] rd,
                      input int nb = 1);
    csb_n = 1'b0;
    for (int i = 8 * nb + 15; i >= 0; i--) begin
      // during readback the data line carries a changing pattern
      if (i >= 8 * nb) sdio = ins[i - 8 * nb];
      else sdio = ins[15] ? ~sdio : wd[i % 8];
      half();
      sclk = 1'b1;
      rd[i%8] = sdo_oe ? sdo : 1'bx;
      half();
      sclk = 1'b0;
    end
    half();
    csb_n = 1'b1;
    sdio  = ~sdio;
    half();
  endtask
endmodule

/* tb/txm_regs_tb.sv */
// self-checking testbench for the transmit multiplier register bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module txm_regs_tb;
  logic       mclk = 1'b0;
  logic       srst = 1'b1;
  logic       csb_n, sclk, h_sdio, sdio_w, sdio_out, sdio_oe, sdo, sdo_oe;
  logic       adv = 1'b0;
  logic       slp_in = 1'b0;
  logic       ld = 1'b0;
  int         xfer_n = 0;
  logic       en, slp, pwr, xfer_p;
  logic [3:0] lo, mid, hi, bin, bout, s1, s2, pa, mode;
  logic [6:0] idx;
  logic [7:0] rd;
  int         errors = 0;
  int         checked = 0;
  always #5 mclk = ~mclk;
  assign sdio_w = sdio_oe ? sdio_out : h_sdio;
  txm_host u_txm_host (.mclk(mclk), .csb_n(csb_n), .sclk(sclk), .sdio(h_sdio),
    .sdo(sdo_oe ? sdo : sdio_w), .sdo_oe(sdo_oe | sdio_oe));
  always @(posedge mclk) if (xfer_p) xfer_n <= xfer_n + 1;
  // part kind value is arbitrary
  txm_regs #(.PART_KIND(8'h3C)) u_txm_regs (.mclk(mclk), .srst(srst), .spi_csb_n(csb_n),
    .spi_sclk(sclk), .spi_sdio_in(sdio_w), .spi_sdio_out(sdio_out), .spi_sdio_oe(sdio_oe),
    .spi_sdo_out(sdo), .spi_sdo_oe(sdo_oe), .tx_seq_reset(1'b0), .tx_seq_advance(adv),
    .tx_latch_load(ld), .mult_sleep(slp_in), .chip_power_up(pwr),
    .multiplier_low_band_bias(lo), .multiplier_mid_band_bias(mid),
    .multiplier_high_band_bias(hi), .buffer_input_stage_bias(bin),
    .buffer_output_stage_bias(bout), .splitter_first_stage_bias(s1),
    .splitter_second_stage_bias(s2), .amplifier_bias_setting(pa), .transmit_seq_enable(en),
    .transmit_sleep_control(slp), .tx_seq_index(idx), .tx_mode_ctrl(mode),
    .shadow_xfer_pulse(xfer_p));
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    u_txm_host.xfer({1'b0, a}, d, rd);
  endtask
  task automatic rdc(input string nm, input logic [14:0] a, input logic [7:0] e);
    u_txm_host.xfer({1'b1, a}, 8'h00, rd);
    `CHK(nm, e, rd)
  endtask
  task automatic step(input bit load = 1'b0);
    if (load) ld = 1'b1;
    else adv = 1'b1;
    repeat (4) @(negedge mclk);
    adv = 1'b0;
    ld  = 1'b0;
    repeat (8) @(negedge mclk);
  endtask
  task automatic t_reset();
    rdc("mult_lm", 15'h0011, 8'hBB);
    rdc("mult_hi", 15'h0012, 8'h0B);
    rdc("rf_buf", 15'h0013, 8'h75);
    rdc("split", 15'h0014, 8'hB5);
    rdc("amp", 15'h0015, 8'h0C);
    rdc("setup", 15'h0016, 8'h10);
    rdc("depth", 15'h0017, 8'h00);
    rdc("modes", 15'h0019, 8'h00);
    `CHK("low_mid", 8'hBB, {mid, lo})
    `CHK("split_pins", 8'hB5, {s2, s1})
    `CHK("en_slp", 2'b00, {en, slp})
  endtask
  task automatic t_bias();
    wr(15'h0011, 8'h4E);
    wr(15'h0012, 8'hF3);
    wr(15'h0013, 8'hA5);
    wr(15'h0014, 8'h3C);
    wr(15'h0015, 8'hFF);
    `CHK("low_mid", 8'h4E, {mid, lo})
    `CHK("high", 4'h3, hi)
    `CHK("buf_pins", 8'hA5, {bout, bin})
    `CHK("split_pins", 8'h3C, {s2, s1})
    `CHK("amp_pin", 4'hF, pa)
    rdc("mult_hi", 15'h0012, 8'h03);
    rdc("amp", 15'h0015, 8'h0F);
    rdc("rf_buf", 15'h0013, 8'hA5);
  endtask
  task automatic t_setup();
    wr(15'h0016, 8'hFF);
    `CHK("en_slp", 2'b11, {en, slp})
    rdc("setup", 15'h0016, 8'hF0);
    wr(15'h0016, 8'h00);
    `CHK("en_slp", 2'b00, {en, slp})
    rdc("setup", 15'h0016, 8'h00);
    wr(15'h0003, 8'hFF);
    rdc("part_kind", 15'h0003, 8'h3C);
  endtask
  task automatic t_mode();
    wr(15'h0000, 8'h24);
    rdc("cfg_a", 15'h0000, 8'h24);
    u_txm_host.xfer({1'b0, 15'h0011}, 8'h66, rd, 2);
    `CHK("low_mid", 8'h66, {mid, lo})
    `CHK("high", 4'h6, hi)
    u_txm_host.xfer({1'b1, 15'h0013}, 8'h00, rd, 2);
    `CHK("split_rd", 8'h3C, rd)
  endtask
  task automatic t_soft();
    wr(15'h0010, 8'h00);
    wr(15'h000F, 8'h03);
    `CHK("xfer_pulses", 1, xfer_n)
    wr(15'h0000, 8'h01);
    `CHK("pwr", 1'b1, pwr)
    rdc("xfer", 15'h000F, 8'h00);
    rdc("rf_buf", 15'h0013, 8'h75);
    rdc("setup", 15'h0016, 8'h10);
    rdc("cfg_a", 15'h0000, 8'h18);
    wr(15'h000A, 8'h5A);
    wr(15'h0000, 8'h80);
    rdc("scratch", 15'h000A, 8'h00);
  endtask
  task automatic t_seq();
    wr(15'h0017, 8'h83);
    rdc("depth", 15'h0017, 8'h03);
    wr(15'h0019, 8'h12);
    wr(15'h001A, 8'h30);
    wr(15'h0016, 8'h90);
    `CHK("idx_mode", 11'h001, {idx, mode})
    step();
    `CHK("idx_mode", 11'h012, {idx, mode})
    step();
    `CHK("idx_mode", 11'h023, {idx, mode})
    step();
    `CHK("idx", 7'h00, idx)
    wr(15'h0016, 8'hB0);
    slp_in = 1'b1;
    step();
    `CHK("idx_held", 7'h00, idx)
    slp_in = 1'b0;
    step();
    `CHK("idx", 7'h01, idx)
    wr(15'h0016, 8'h80);
    `CHK("latched", 11'h010, {idx, mode})
    step(1'b1);
    `CHK("latched", 11'h012, {idx, mode})
    step();
    `CHK("latched", 11'h022, {idx, mode})
  endtask
  task automatic complete_run();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge mclk);
    srst = 1'b0;
    repeat (2) @(negedge mclk);
    t_reset();
    t_bias();
    t_setup();
    t_mode();
    t_soft();
    t_seq();
    complete_run();
  end
  // the whole run takes about 17500 cycles; give up at 40000, a little over twice that
  initial begin
    #400us;
    errors++;
    complete_run();
  end
endmodule
